// ==== ssr_map.svh ====
// Constants for the serial shift and store register
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
`define SSR_WIDTH 8
`define SSR_FIFO_DEPTH 16
`define SSR_PIN_COUNT 5
`define SSR_PIN_SERIAL 0
`define SSR_PIN_SHIFT_CLK 1
`define SSR_PIN_SHIFT_CLR_N 2
`define SSR_PIN_STORE_CLK 3
`define SSR_PIN_STORE_CLR_N 4
`define SSR_PIN_RESET_VAL 5'h00
`define SSR_WORD_RESET_VAL 8'h00
`endif

// ==== ssr_pkg.sv ====
// Types for the serial shift and store register
`default_nettype none
`include "ssr_map.svh"
package ssr_pkg;
  typedef logic [`SSR_WIDTH-1:0] ssr_word_t;
  typedef logic [`SSR_PIN_COUNT-1:0] ssr_pins_t;
endpackage : ssr_pkg
`default_nettype wire

// ==== ssr_fifo.sv ====
// Snapshot FIFO between the shift chain and the storage register
`timescale 1ns/1ps
`default_nettype none
module ssr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Depth must be a power of two so the pointers wrap by themselves
  assign in_ready_o = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : ssr_fifo
`default_nettype wire

// ==== ssr_top.sv ====
// Eight-stage serial shift chain feeding an eight-bit storage register
`timescale 1ns/1ps
`default_nettype none
`include "ssr_map.svh"
module ssr_top (
  // System clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Serial side pins
  input wire logic serial_in_i,
  input wire logic shift_clock_i,
  input wire logic shift_clear_n_i,
  // Storage side pins
  input wire logic store_clock_i,
  input wire logic store_clear_n_i,
  // Output flow control
  input wire logic out_hold_i,
  output logic store_ready_o,
  // Outputs
  output logic [`SSR_WIDTH-1:0] parallel_out_o,
  output logic cascade_out_o
);
  localparam ssr_pkg::ssr_pins_t PIN_RST = `SSR_PIN_RESET_VAL;
  localparam ssr_pkg::ssr_word_t WORD_RST = `SSR_WORD_RESET_VAL;

  ssr_pkg::ssr_pins_t pin_raw;
  ssr_pkg::ssr_pins_t meta_q;
  ssr_pkg::ssr_pins_t sync_q;
  ssr_pkg::ssr_pins_t prev_q;
  ssr_pkg::ssr_word_t shift_q;
  ssr_pkg::ssr_word_t store_q;
  ssr_pkg::ssr_word_t fifo_data;
  logic serial_s;
  logic shift_clr_s;
  logic store_clr_s;
  logic shift_rise;
  logic store_rise;
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_push;
  logic fifo_flush;
  logic shift_clk_s;
  logic shift_clk_prev;
  logic store_clk_s;
  logic store_clk_prev;
  logic store_load;
  logic drain_ready;
  ssr_pkg::ssr_word_t chain_in;

  assign pin_raw[`SSR_PIN_SERIAL] = serial_in_i;
  assign pin_raw[`SSR_PIN_SHIFT_CLK] = shift_clock_i;
  assign pin_raw[`SSR_PIN_SHIFT_CLR_N] = shift_clear_n_i;
  assign pin_raw[`SSR_PIN_STORE_CLK] = store_clock_i;
  assign pin_raw[`SSR_PIN_STORE_CLR_N] = store_clear_n_i;

  // Every pin passes two flops; the first one feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < `SSR_PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          meta_q[gi] <= PIN_RST[gi];
          sync_q[gi] <= PIN_RST[gi];
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Delayed copy of the settled level; the clock pins build their edges from it
  generate
    for (gi = 0; gi < `SSR_PIN_COUNT; gi++) begin : g_prev
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          prev_q[gi] <= PIN_RST[gi];
        end else begin
          prev_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  assign serial_s = sync_q[`SSR_PIN_SERIAL];
  assign shift_clr_s = !sync_q[`SSR_PIN_SHIFT_CLR_N];
  assign store_clr_s = !sync_q[`SSR_PIN_STORE_CLR_N];
  assign shift_clk_s = sync_q[`SSR_PIN_SHIFT_CLK];
  assign shift_clk_prev = prev_q[`SSR_PIN_SHIFT_CLK];
  assign store_clk_s = sync_q[`SSR_PIN_STORE_CLK];
  assign store_clk_prev = prev_q[`SSR_PIN_STORE_CLK];
  // Only low-to-high transitions count; falling ones are ignored
  assign shift_rise = shift_clk_s && !shift_clk_prev;
  assign store_rise = store_clk_s && !store_clk_prev;

  // Stage 0 takes the serial pin, every later stage its lower neighbour
  assign chain_in = {shift_q[`SSR_WIDTH-2:0], serial_s};

  // Shift chain, one flop per stage; clear is a level and wins over any edge
  generate
    for (gi = 0; gi < `SSR_WIDTH; gi++) begin : g_stage
      always_ff @(posedge ref_clk_i) begin
        if (rst_i || shift_clr_s) begin
          shift_q[gi] <= WORD_RST[gi];
        end else if (shift_rise) begin
          shift_q[gi] <= chain_in[gi];
        end
      end
    end
  endgenerate

  assign cascade_out_o = shift_q[`SSR_WIDTH-1];

  // Snapshot taken from the chain value before this cycle's shift,
  // so tied clocks leave storage one pulse behind the chain
  assign fifo_push = store_rise && !store_clr_s;
  // Clearing storage also drops queued snapshots, else stale data would reappear
  assign fifo_flush = store_clr_s;
  assign store_ready_o = fifo_ready;
  // Draining and loading share one condition, so no snapshot is popped unseen
  assign drain_ready = !out_hold_i;
  assign store_load = fifo_valid && drain_ready;

  ssr_fifo #(
    .WIDTH(`SSR_WIDTH),
    .DEPTH(`SSR_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .flush_i(fifo_flush),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_ready),
    .in_data_i(shift_q),
    .out_valid_o(fifo_valid),
    .out_ready_i(drain_ready),
    .out_data_o(fifo_data)
  );

  // Storage register drains the FIFO unless the output is held
  generate
    for (gi = 0; gi < `SSR_WIDTH; gi++) begin : g_store
      always_ff @(posedge ref_clk_i) begin
        if (rst_i || store_clr_s) begin
          store_q[gi] <= WORD_RST[gi];
        end else if (store_load) begin
          store_q[gi] <= fifo_data[gi];
        end
      end
      // Output bit n follows storage bit n, which came from chain stage n
      assign parallel_out_o[gi] = store_q[gi];
    end
  endgenerate
endmodule : ssr_top
`default_nettype wire

// ==== ssr_monitor.sv ====
// Port checker for the shift and store register
`timescale 1ns/1ps
`default_nettype none
module ssr_monitor (
  // Clock, reset and pins
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic shift_clock_i,
  input wire logic shift_clear_n_i,
  input wire logic store_clear_n_i,
  input wire logic out_hold_i,
  // Outputs
  input wire logic store_ready_o,
  input wire logic [7:0] parallel_out_o,
  input wire logic cascade_out_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Six samples cover the pin synchronisers plus the output register
  sequence s_chain_clr;
    !shift_clear_n_i[*6];
  endsequence
  a_reset_outs: assert property ($fell(rst_i) |-> !parallel_out_o && !cascade_out_o
    && store_ready_o) else $error("outputs not cleared by reset");
  a_chain_clear: assert property (s_chain_clr |-> !cascade_out_o) else $error("chain kept");
  a_store_clear: assert property (!store_clear_n_i[*6] |-> parallel_out_o == 8'h00)
    else $error("storage kept");
  a_clear_flush: assert property (!store_clear_n_i[*6] |-> store_ready_o)
    else $error("flush missed");
  a_chain_still: assert property (($stable(shift_clock_i) && shift_clear_n_i)[*6]
    |-> $stable(cascade_out_o)) else $error("chain moved");
  a_store_still: assert property ((out_hold_i && store_clear_n_i)[*6]
    |-> $stable(parallel_out_o)) else $error("storage moved");
  a_load_cause: assert property ($changed(parallel_out_o) && parallel_out_o != 8'h00
    |-> !$past(out_hold_i)) else $error("load while held");
  a_shift_cause: assert property ($changed(cascade_out_o) && cascade_out_o
    |-> $past(shift_clock_i, 2) && !$past(shift_clock_i, 5)) else $error("no shift");
endmodule : ssr_monitor
`default_nettype wire

// ==== ssr_host.sv ====
// Host model driving the serial and clock pins
`timescale 1ns/1ps
`default_nettype none
module ssr_host (
  // Clock
  input wire logic ref_clk_i,
  // Pins toward the register
  output logic serial_in_o,
  output logic shift_clock_o,
  output logic store_clock_o
);
  initial begin
    serial_in_o = 1'b0;
    shift_clock_o = 1'b0;
    store_clock_o = 1'b0;
  end
  // Four cycles a level stays clear of the two-cycle pulse minimum
  task automatic tick(input logic bit_v, input logic shf, input logic sto);
    @(negedge ref_clk_i);
    serial_in_o = bit_v;
    @(negedge ref_clk_i);
    shift_clock_o = shf;
    store_clock_o = sto;
    repeat (4) @(negedge ref_clk_i);
    shift_clock_o = 1'b0;
    store_clock_o = 1'b0;
    repeat (4) @(negedge ref_clk_i);
  endtask : tick
  task automatic send(input logic [7:0] word, input logic store);
    for (int i = 7; i >= 0; i--) tick(word[i], 1'b1, 1'b0);
    if (store) tick(1'b0, 1'b0, 1'b1);
  endtask : send
endmodule : ssr_host
`default_nettype wire

// ==== testbench.sv ====
// Testbench for the shift and store register
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic shift_clear_n = 1'b0;
  logic store_clear_n = 1'b0;
  logic out_hold = 1'b0;
  logic serial_in, shift_clock, store_clock, ready, cascade;
  logic [7:0] par;
  int mismatches = 0;
  int total_checks = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  ssr_host ssr_host_i (.ref_clk_i(ref_clk_i), .serial_in_o(serial_in),
    .shift_clock_o(shift_clock), .store_clock_o(store_clock));
  ssr_top ssr_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .serial_in_i(serial_in),
    .shift_clock_i(shift_clock), .shift_clear_n_i(shift_clear_n), .store_clock_i(store_clock),
    .store_clear_n_i(store_clear_n), .out_hold_i(out_hold), .store_ready_o(ready),
    .parallel_out_o(par), .cascade_out_o(cascade));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : wait_n
  task automatic t_tied();
    ssr_host_i.send(8'hC3, 1'b1);
    check("word", 8'hC3, par);
    check("cascade", 8'h01, {7'h00, cascade});
    ssr_host_i.tick(1'b1, 1'b1, 1'b1);
    check("tied", 8'hC3, par);
    ssr_host_i.tick(1'b0, 1'b0, 1'b1);
    check("lag", 8'h87, par);
  endtask : t_tied
  task automatic t_clear();
    store_clear_n = 1'b0;
    wait_n(6);
    check("store clr", 8'h00, par);
    store_clear_n = 1'b1;
    wait_n(4);
    ssr_host_i.tick(1'b0, 1'b0, 1'b1);
    check("chain kept", 8'h87, par);
    shift_clear_n = 1'b0;
    ssr_host_i.tick(1'b1, 1'b1, 1'b0);
    check("casc clr", 8'h00, {7'h00, cascade});
    shift_clear_n = 1'b1;
    wait_n(4);
    ssr_host_i.tick(1'b0, 1'b0, 1'b1);
    check("chain clr", 8'h00, par);
  endtask : t_clear
  // Seventeen snapshots while held: sixteen fill the FIFO, the last is dropped
  task automatic t_fifo();
    out_hold = 1'b1;
    ssr_host_i.send(8'h5A, 1'b0);
    repeat (17) ssr_host_i.tick(1'b0, 1'b0, 1'b1);
    check("full", 8'h00, {7'h00, ready});
    check("held", 8'h00, par);
    out_hold = 1'b0;
    wait_n(40);
    check("drained", 8'h01, {7'h00, ready});
    check("loaded", 8'h5A, par);
  endtask : t_fifo
  // Storage clear while the FIFO is full must drop every queued snapshot
  task automatic t_flush();
    out_hold = 1'b1;
    repeat (16) ssr_host_i.tick(1'b0, 1'b0, 1'b1);
    check("refill", 8'h00, {7'h00, ready});
    store_clear_n = 1'b0;
    wait_n(6);
    check("flushed", 8'h01, {7'h00, ready});
    check("clr held", 8'h00, par);
    store_clear_n = 1'b1;
    out_hold = 1'b0;
    wait_n(40);
    check("no stale", 8'h00, par);
  endtask : t_flush
  initial begin
    wait_n(16);
    rst_i = 1'b0;
    shift_clear_n = 1'b1;
    store_clear_n = 1'b1;
    wait_n(4);
    t_tied();
    t_clear();
    t_fifo();
    t_flush();
    end_sim();
  end
  initial begin
    #60000;
    mismatches++;
    end_sim();
  end
endmodule : testbench
bind ssr_top ssr_monitor ssr_monitor_i (.*);
`default_nettype wire
